// file: rtl/sildrv_core.sv
// Serial-input latched driver core: shift register on link clock, latches on i_clk
`timescale 1ns/1ps
module sildrv_core
   import sildrv_pkg::*;
#(
   parameter int STAGES = sildrv_pkg::SILDRV_STAGES
) (
   // System clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   // Serial link from the controller
   input  wire logic                        i_sclk,
   input  wire logic                        i_sdata,
   output logic                             o_sdata_cascade,
   // Control pins
   input  wire sildrv_pkg::sildrv_ctrl_type i_ctrl,
   // Parallel outputs
   output logic [STAGES-1:0]                parallel_out_n
);
   import sildrv_pkg::*;

   // Link domain: shift register, no reset, as the part has none.
   // A power-up value stands in for it: the link clock stops between frames,
   // so a reset could not reach this domain, and a known start keeps the
   // cascade pin and the shift checks clean before the first full frame.
   logic [STAGES-1:0] shift_r = '0;
   logic [STAGES-1:0] shift_nxt;

   // System domain state
   logic [STAGES-1:0] shift_sync;
   logic [1:0]        ctrl_sync;
   logic [STAGES-1:0] latch_r;
   logic [STAGES-1:0] latch_nxt;
   logic [STAGES-1:0] out_r;
   logic [STAGES-1:0] out_nxt;
   logic              load_s;
   logic              blank_s;

   // Shift: new bit enters stage one, oldest bit leaves at the far end
   always_comb begin
      shift_nxt = {shift_r[STAGES-2:0], i_sdata};
   end

   // Data is sampled directly on the link clock edge, so its setup is the controller's duty
   always_ff @(posedge i_sclk) begin
      shift_r <= shift_nxt;
   end

   // Cascade output changes only on the link clock, like the original part
   assign o_sdata_cascade = shift_r[STAGES-1];

   // Register contents cross as a level; a shift mid-sample may show one stale
   // stage for a cycle, which settles because the link runs well below i_clk
   sildrv_sync #(
      .WIDTH (STAGES)
   ) u_shift_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (shift_r),
      .o_sync  (shift_sync)
   );

   // Load and blanking pins pass two flops before use
   sildrv_sync #(
      .WIDTH (2)
   ) u_ctrl_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_ctrl.load, i_ctrl.blank}),
      .o_sync  (ctrl_sync)
   );

   assign load_s  = ctrl_sync[1];
   assign blank_s = ctrl_sync[0];

   // Latches follow the register while load is high, hold otherwise;
   // blanking does not feed latch_nxt so it cannot touch them
   always_comb begin
      latch_nxt = latch_r;
      if (load_s) begin
         latch_nxt = shift_sync;
      end
      // Blanking masks the drivers only
      out_nxt = blank_s ? {STAGES{SILDRV_OFF}} : latch_nxt;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         latch_r <= SILDRV_CLEAR;
         out_r   <= SILDRV_CLEAR;
      end else begin
         latch_r <= latch_nxt;
         out_r   <= out_nxt;
      end
   end

   assign parallel_out_n = out_r;

   // Outputs off one cycle after synchronised blanking is high
   a_blank_forces_off: assert property (
      @(posedge i_clk) disable iff (i_rst)
      blank_s |=> (parallel_out_n == '0))
      else $error("outputs not off while blanked");

   // Outputs equal latches one cycle after blanking low
   a_unblank_follows: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !blank_s |=> (parallel_out_n == latch_r))
      else $error("outputs do not follow latches");

   // Latches copy the register while load is high
   a_load_copies: assert property (
      @(posedge i_clk) disable iff (i_rst)
      load_s |=> (latch_r == $past(shift_sync)))
      else $error("latch missed load");

   // Transparent across two consecutive load cycles
   a_load_transparent: assert property (
      @(posedge i_clk) disable iff (i_rst)
      load_s [*2] |=> (latch_r == $past(shift_sync)))
      else $error("latch not transparent");

   // Latches hold with load low, blanking or not
   a_latch_holds: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !load_s |=> $stable(latch_r))
      else $error("latch changed without load");

   // Blanking edge alone leaves latches unchanged
   a_blank_no_touch: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ($changed(blank_s) && !load_s) |=> $stable(latch_r))
      else $error("blanking altered latches");

   // Serial input lands in stage one
   a_shift_capture: assert property (
      @(posedge i_sclk)
      1'b1 |=> (shift_r[0] == $past(i_sdata)))
      else $error("serial bit not captured");

   // Every stage advances toward the cascade end
   a_shift_advance: assert property (
      @(posedge i_sclk)
      1'b1 |=> (shift_r[STAGES-1:1] == $past(shift_r[STAGES-2:0])))
      else $error("shift did not advance");

   // Cascade output is the last stage
   a_cascade_end: assert property (
      @(posedge i_sclk)
      1'b1 |=> (o_sdata_cascade == $past(shift_r[STAGES-2])))
      else $error("cascade output wrong");

   // Cascade pin always shows the far stage
   a_cascade_tracks: assert property (
      @(posedge i_sclk)
      1'b1 |=> (o_sdata_cascade == shift_r[STAGES-1]))
      else $error("cascade pin not last stage");

   // Reset clears latches and outputs on the next edge
   a_reset_clear: assert property (
      @(posedge i_clk)
      i_rst |=> ((latch_r == '0) && (parallel_out_n == '0)))
      else $error("reset did not clear state");

   // Rising blanking turns every output off on the next cycle
   a_blank_rise_off: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $rose(blank_s) |=> (parallel_out_n == '0))
      else $error("outputs on after blank rise");

   // Steady blanking keeps outputs off
   a_blank_steady_off: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (blank_s && $past(blank_s)) |-> (parallel_out_n == '0))
      else $error("outputs on while blanked");

   // Idle load and no blanking: outputs show the held latches
   a_hold_outputs: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (!load_s && !blank_s) |=> (parallel_out_n == $past(latch_r)))
      else $error("outputs differ from held latches");

   // Loading under blanking still fills the latches
   a_load_blanked: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (load_s && blank_s) |=> ((latch_r == $past(shift_sync)) && (parallel_out_n == '0)))
      else $error("blanked load misbehaved");

   // Unblanked load drives the register straight to the outputs
   a_unblank_loaded: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (load_s && !blank_s) |=> (parallel_out_n == $past(shift_sync)))
      else $error("outputs missed loaded data");

   // An output is never on unless its latch is set
   a_out_subset: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ((parallel_out_n & ~latch_r) == '0))
      else $error("output on without latch");

   // Falling blanking shows the latches again
   a_unblank_shows: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(blank_s) |=> (parallel_out_n == latch_r))
      else $error("latches not shown after unblank");

   // Dropping load freezes the latches
   a_load_fall_holds: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(load_s) |=> $stable(latch_r))
      else $error("latch moved after load fell");
endmodule

// file: rtl/sildrv_pkg.sv
// Package: widths, pin group and constants for the serial-input latched driver
package sildrv_pkg;
   localparam int          SILDRV_STAGES      = 20;       // Register and latch width
   localparam int          SILDRV_SYNC_DEPTH  = 2;        // Flip-flops per synchroniser
   localparam int          SILDRV_SCLK_MAX_MHZ = 10;      // Shift clock ceiling, for reference
   localparam logic [19:0] SILDRV_CLEAR       = 20'h0_0000;
   localparam logic        SILDRV_OFF         = 1'b0;     // Disabled level of an output

   // Control pins from the controller, all asynchronous to i_clk
   typedef struct packed {
      logic load;    // Latch-load, level sensitive
      logic blank;   // Blanking, high forces outputs off
   } sildrv_ctrl_type;
endpackage

// file: rtl/sildrv_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module sildrv_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   // First stage feeds only the second
   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule

// file: test/sildrv_ctl_model.sv
// Controller model: shifts frames into the driver on its own link clock
`timescale 1ns/1ps
module sildrv_ctl_model (
   // Serial link
   output logic o_sclk,
   output logic o_sdata
);
   initial begin
      o_sclk  = 1'b0;
      o_sdata = 1'b0;
   end
   // First bit out is f[19]; clock stands still between frames
   task automatic send(input logic [19:0] f);
      for (int k = 19; k >= 0; k--) begin
         o_sdata = f[k];
         #6 o_sclk = 1'b1; // 12 ns period, past the ceiling to stress the crossing
         #6 o_sclk = 1'b0;
      end
      o_sdata = ~f[0]; // Released line must not look like valid data
   endtask
endmodule

// file: test/tb_sildrv_core.sv
// Self-checking bench for the serial-input latched driver core
`timescale 1ns/1ps
module tb_sildrv_core;
   import sildrv_pkg::*;
   typedef struct {logic [19:0] f; logic b; logic [19:0] e;} sildrv_row_type;
   logic            i_clk    = 1'b0;
   logic            i_rst    = 1'b1;
   logic            sclk;
   logic            sdata;
   logic            cas;
   sildrv_ctrl_type ctrl     = '0;
   logic [19:0]     q;
   int              n_errors = 0;
   int              compares = 0;
   int              cyc      = 0;
   sildrv_row_type  rows[3]  = '{'{20'hA_5A5A, 1'b0, 20'hA_5A5A},
                                 '{20'h8_0001, 1'b0, 20'h8_0001},
                                 '{20'h3_C3C3, 1'b1, 20'h0_0000}};
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
$display("FAIL %s exp %h got %h", n, e, s); end end

   sildrv_core dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_sdata(sdata),
      .o_sdata_cascade(cas), .i_ctrl(ctrl), .parallel_out_n(q));
   sildrv_ctl_model ctl_u (.o_sclk(sclk), .o_sdata(sdata));

   always #10 i_clk = ~i_clk;
   // Whole run needs about 160 cycles; a hang is cut at 2000
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Pulse load long enough to clear the synchroniser and output stage
   task automatic strobe();
      tick(4);
      ctrl.load = 1'b1;
      tick(6);
      ctrl.load = 1'b0;
      tick(6);
   endtask
   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      tick(20);
      `CHK("reset out", 20'h0_0000, q)
      i_rst = 1'b0;
      foreach (rows[i]) begin
         ctrl.blank = rows[i].b;
         ctl_u.send(rows[i].f);
         strobe();
         `CHK("out", rows[i].e, q)
         `CHK("cascade", rows[i].f[19], cas)
      end
      // New frame with load low, then unblank: old latch contents must show
      ctl_u.send(20'h0_1234);
      tick(4);
      ctrl.blank = 1'b0;
      tick(6);
      `CHK("held", 20'h3_C3C3, q)
      // Shifting while load stays high: blanking covers the entry, then outputs follow
      ctrl.blank = 1'b1;
      ctrl.load = 1'b1;
      tick(2);
      ctl_u.send(20'h5_5AA5);
      tick(8);
      `CHK("blanked load", 20'h0_0000, q)
      ctrl.blank = 1'b0;
      tick(4);
      `CHK("transparent", 20'h5_5AA5, q)
      ctrl.load = 1'b0;
      tick(2);
      i_rst = 1'b1;
      tick(4);
      `CHK("second reset", 20'h0_0000, q)
      i_rst = 1'b0;
      final_report();
   end
endmodule
